//--- cosl_pkg.sv
// What this block does
// - after init the node enters pre-operational by itself
// - pre-operational serves sdo, sends no pdo and no emergency
// - operational may send pdo and emergency unpolled
// - stopped stays silent but still answers node guarding and lss
// - with a node id the master moves states via nmt
// - node ids 1 to 127 accepted, 0 refused
// - factory reset sets node id 6
// - eight bit rates selectable, 125 kbit/s default
// - changed node id applies on reset command 81
// - lss telegrams are 8 bytes, specifier first, unused zero
// - lss replies use 7e4h, requests use 7e5h
// - lss selection by vendor, product, revision, serial
// - every sdo request in pre-operational or operational gets a response when the tx path is free
// - sdo server performs read or write then replies
// - sdo request id 600h plus node, index, subindex, data
// - command code picks read or write; errors give 4-byte code
// - sdo writes other than pdo mapping are committed to nonvolatile store at once
// - pdo mapping is not stored; it survives reset command 81 and is cleared only by rst
// - tpdo uses 180h plus node, up to 8 bytes, unacknowledged
// - six transmit pdos and one receive pdo
// - tpdo comm at 1800h-1805h, mapping at 1a00h-1a05h
// - mapping entries name an app_bytes byte in bits 23:16, 8 bits each; assembled in order
// - bit 31 of subindex 01h of a tpdo comm object disables it
//
// Purpose: constants and frame types of the canopen slave layer
// Assumes: 11-bit identifiers, frames carried as packed structs
// Notes:   state codes are gray
`default_nettype none
package cosl_pkg;
    typedef struct packed {
        logic [10:0] id;
        logic [3:0]  len;
        logic [63:0] data;   // byte 0 in bits 7:0
    } cosl_frame_type;

    typedef enum logic [2:0] {
        COSL_INIT    = 3'b000,
        COSL_PREOP   = 3'b001,
        COSL_OPER    = 3'b011,
        COSL_STOPPED = 3'b010
    } cosl_state_type;

    localparam logic [10:0] NMT_ID       = 11'h000;
    localparam logic [10:0] GUARD_BASE   = 11'h700;
    localparam logic [10:0] SDO_RX_BASE  = 11'h600;
    localparam logic [10:0] SDO_TX_BASE  = 11'h580;
    localparam logic [10:0] TPDO_BASE    = 11'h180;
    localparam logic [10:0] TPDO_STEP    = 11'h100;
    localparam logic [10:0] RPDO_BASE    = 11'h200;
    localparam logic [10:0] EMCY_BASE    = 11'h080;
    localparam logic [10:0] LSS_TX_ID    = 11'h7e4;
    localparam logic [10:0] LSS_RX_ID    = 11'h7e5;
    localparam logic [3:0]  FRAME_LEN    = 4'h8;

    localparam logic [7:0] NMT_START     = 8'h01;
    localparam logic [7:0] NMT_STOP      = 8'h02;
    localparam logic [7:0] NMT_PREOP     = 8'h80;
    localparam logic [7:0] NMT_RESET     = 8'h81;
    localparam logic [7:0] NMT_RESET_COM = 8'h82;

    localparam logic [6:0] NODE_ID_DEFAULT = 7'h06;
    localparam logic [2:0] RATE_DEFAULT    = 3'h3;  // code for 125 kbit/s
    // rate codes 0..7 = 10,20,50,125,250,500,800,1000 kbit/s

    localparam logic [7:0] SDO_CMD_READ   = 8'h40;
    localparam logic [7:0] SDO_CMD_WR_MSK = 8'he0;
    localparam logic [7:0] SDO_CMD_WRITE  = 8'h20;
    localparam logic [7:0] SDO_RSP_WRITE  = 8'h60;
    localparam logic [7:0] SDO_RSP_READ   = 8'h43;
    localparam logic [7:0] SDO_RSP_ABORT  = 8'h80;
    localparam logic [31:0] ABORT_NO_OBJ  = 32'h0602_0000;
    localparam logic [31:0] ABORT_RO      = 32'h0601_0002;
    localparam logic [31:0] ABORT_CMD     = 32'h0504_0001;
    localparam logic [31:0] ABORT_RANGE   = 32'h0609_0030;

    localparam logic [15:0] OBJ_IDENTITY  = 16'h1018;
    localparam logic [15:0] OBJ_TPDO_COMM = 16'h1800;
    localparam logic [15:0] OBJ_TPDO_MAP  = 16'h1a00;
    localparam logic [15:0] OBJ_NODE_ID   = 16'h2100;
    localparam logic [15:0] OBJ_RATE      = 16'h2101;
    localparam int          COMM_DIS_BIT  = 31;

    localparam logic [7:0] LSS_SW_GLOBAL  = 8'h04;
    localparam logic [7:0] LSS_SEL_VENDOR = 8'h40;
    localparam logic [7:0] LSS_SEL_SERIAL = 8'h43;
    localparam logic [7:0] LSS_SEL_ACK    = 8'h44;
    localparam logic [7:0] LSS_CFG_ID     = 8'h11;
    localparam logic [7:0] LSS_CFG_RATE   = 8'h13;
    localparam logic [7:0] LSS_STORE      = 8'h17;
endpackage
`default_nettype wire

//--- cosl_slave.sv
// Purpose: canopen slave communication layer (nmt, sdo, lss, tpdo)
// Assumes: one received frame per rx_valid pulse, tx held until tx_ready
// Notes:   objects 1a0xh hold up to 8 mapping entries of 8-bit sources
`default_nettype none
module cosl_slave #(
    parameter int NUM_TPDO  = 6,
    parameter int MAP_DEPTH = 8,
    parameter logic [31:0] VENDOR_CODE  = 32'h0000_0001, // arbitrary
    parameter logic [31:0] PRODUCT_CODE = 32'h0000_0002, // arbitrary
    parameter logic [31:0] REVISION     = 32'h0000_0003, // arbitrary
    parameter logic [31:0] SERIAL       = 32'h0000_0004  // arbitrary
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst,
    // received frames
    input  wire cosl_pkg::cosl_frame_type rx_frame,
    input  wire logic                     rx_valid,
    // frames to transmit
    output var  cosl_pkg::cosl_frame_type tx_frame,
    output logic                          tx_valid,
    input  wire logic                     tx_ready,
    // application side
    input  wire logic                     app_init_done,
    input  wire logic [NUM_TPDO-1:0]      tpdo_trigger,
    input  wire logic                     emcy_request,
    input  wire logic [63:0]              emcy_data,
    input  wire logic [255:0]             app_bytes,
    // nonvolatile store
    input  wire logic                     factory_reset,
    output logic                          nv_write,
    output logic [15:0]                   nv_index,
    output logic [31:0]                   nv_data,
    // status
    output cosl_pkg::cosl_state_type      nmt_state,
    output logic [6:0]                    node_id,
    output logic [2:0]                    bit_rate,
    output logic [7:0]                    rpdo_data [0:7]
);
    initial begin
        if (NUM_TPDO < 1 || NUM_TPDO > 8 || MAP_DEPTH != 8)
            $error("cosl_slave: unsupported parameters");
    end

    cosl_pkg::cosl_state_type state_r, state_nxt;
    logic [6:0]  node_r, pend_node_r;
    logic [2:0]  rate_r;
    logic        lss_sel_r, guard_tog_r;
    logic [1:0]  lss_step_r;
    logic [NUM_TPDO-1:0] tpdo_dis_r, tpdo_pend_r;
    logic [7:0]  map_src_r [0:NUM_TPDO-1][0:MAP_DEPTH-1];
    logic [3:0]  map_cnt_r [0:NUM_TPDO-1];
    logic        emcy_pend_r;
    cosl_pkg::cosl_frame_type tx_r;
    logic        tx_v_r;

    // incoming frame decode
    wire [7:0]  b0 = rx_frame.data[7:0];
    wire [15:0] idx = rx_frame.data[23:8];
    wire [7:0]  sub = rx_frame.data[31:24];
    wire [31:0] wdat = rx_frame.data[63:32];
    wire        has_id = (node_r != 7'h00);
    wire is_nmt = rx_valid && rx_frame.id == cosl_pkg::NMT_ID
        && (rx_frame.data[15:8] == 8'h00
            || rx_frame.data[14:8] == node_r);
    wire is_guard = rx_valid
        && rx_frame.id == (cosl_pkg::GUARD_BASE | {4'h0, node_r});
    wire is_sdo = rx_valid && state_r != cosl_pkg::COSL_STOPPED
        && state_r != cosl_pkg::COSL_INIT
        && rx_frame.id == (cosl_pkg::SDO_RX_BASE | {4'h0, node_r});
    wire is_lss = rx_valid && rx_frame.id == cosl_pkg::LSS_RX_ID;
    wire is_rpdo = rx_valid && state_r == cosl_pkg::COSL_OPER
        && rx_frame.id == (cosl_pkg::RPDO_BASE | {4'h0, node_r});
    wire can_push = !tx_v_r || tx_ready;

    // nmt transitions
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            cosl_pkg::COSL_INIT:
                if (app_init_done && has_id)
                    state_nxt = cosl_pkg::COSL_PREOP;
            default: begin
                if (is_nmt) begin
                    if (b0 == cosl_pkg::NMT_START)
                        state_nxt = cosl_pkg::COSL_OPER;
                    else if (b0 == cosl_pkg::NMT_STOP)
                        state_nxt = cosl_pkg::COSL_STOPPED;
                    else if (b0 == cosl_pkg::NMT_PREOP)
                        state_nxt = cosl_pkg::COSL_PREOP;
                    else if (b0 == cosl_pkg::NMT_RESET
                          || b0 == cosl_pkg::NMT_RESET_COM)
                        state_nxt = cosl_pkg::COSL_INIT;
                end
            end
        endcase
    end

    // sdo object access
    function automatic logic [2:0] pdo_of(input logic [15:0] i);
        return i[2:0];
    endfunction
    wire is_comm = idx[15:3] == cosl_pkg::OBJ_TPDO_COMM[15:3]
        && pdo_of(idx) < NUM_TPDO;
    wire is_map  = idx[15:3] == cosl_pkg::OBJ_TPDO_MAP[15:3]
        && pdo_of(idx) < NUM_TPDO;
    wire is_ident = idx == cosl_pkg::OBJ_IDENTITY && sub >= 8'h01
        && sub <= 8'h04;
    wire sdo_rd = b0 == cosl_pkg::SDO_CMD_READ;
    wire sdo_wr = (b0 & cosl_pkg::SDO_CMD_WR_MSK) == cosl_pkg::SDO_CMD_WRITE;
    wire [31:0] ident_val = sub == 8'h01 ? VENDOR_CODE
        : sub == 8'h02 ? PRODUCT_CODE : sub == 8'h03 ? REVISION : SERIAL;
    wire [2:0] pi = pdo_of(idx);
    wire [31:0] rd_val =
        is_ident ? ident_val
      : idx == cosl_pkg::OBJ_NODE_ID ? {25'h0, node_r}
      : idx == cosl_pkg::OBJ_RATE ? {29'h0, rate_r}
      : is_comm ? {tpdo_dis_r[pi], 20'h0,
                   cosl_pkg::TPDO_BASE + {4'h0, node_r}}
      : is_map && sub == 8'h00 ? {28'h0, map_cnt_r[pi]}
      : is_map ? {8'h00, map_src_r[pi][sub[2:0] - 3'h1], 16'h0008}
      : 32'h0;
    wire rd_ok = is_ident || idx == cosl_pkg::OBJ_NODE_ID
        || idx == cosl_pkg::OBJ_RATE || is_comm
        || (is_map && sub <= 8'h08);
    wire wr_id_ok = idx == cosl_pkg::OBJ_NODE_ID && wdat >= 32'h1
        && wdat <= 32'h7f;
    wire wr_rate_ok = idx == cosl_pkg::OBJ_RATE && wdat <= 32'h7;
    wire wr_comm_ok = is_comm && sub == 8'h01;
    wire wr_map_ok = is_map && sub <= 8'h08 && (sub != 8'h00
        || wdat <= 32'h8);
    wire wr_ok = wr_id_ok || wr_rate_ok || wr_comm_ok || wr_map_ok;
    wire [31:0] abort_code =
        !(sdo_rd || sdo_wr) ? cosl_pkg::ABORT_CMD
      : sdo_wr && (is_ident || (is_comm && sub != 8'h01))
          ? cosl_pkg::ABORT_RO
      : sdo_wr && (idx == cosl_pkg::OBJ_NODE_ID
          || idx == cosl_pkg::OBJ_RATE || is_map)
          ? cosl_pkg::ABORT_RANGE
      : cosl_pkg::ABORT_NO_OBJ;
    wire [7:0] sdo_rsp_cmd = (sdo_rd && rd_ok) ? cosl_pkg::SDO_RSP_READ
        : (sdo_wr && wr_ok) ? cosl_pkg::SDO_RSP_WRITE
        : cosl_pkg::SDO_RSP_ABORT;
    wire [31:0] sdo_rsp_dat = (sdo_rd && rd_ok) ? rd_val
        : (sdo_wr && wr_ok) ? 32'h0 : abort_code;

    // lss: select by identity, then configure
    wire [31:0] lss_val = rx_frame.data[39:8];
    wire [31:0] lss_want = lss_step_r == 2'd0 ? VENDOR_CODE
        : lss_step_r == 2'd1 ? PRODUCT_CODE
        : lss_step_r == 2'd2 ? REVISION : SERIAL;
    wire lss_sel_hit = is_lss && b0 == cosl_pkg::LSS_SEL_VENDOR
        + {6'h0, lss_step_r} && lss_val == lss_want;
    wire lss_cfg = is_lss && lss_sel_r && (b0 == cosl_pkg::LSS_CFG_ID
        || b0 == cosl_pkg::LSS_CFG_RATE || b0 == cosl_pkg::LSS_STORE);
    wire lss_id_ok = rx_frame.data[15:8] >= 8'h01
        && rx_frame.data[15:8] <= 8'h7f;
    wire [7:0] lss_err = (b0 == cosl_pkg::LSS_CFG_ID && !lss_id_ok)
        || (b0 == cosl_pkg::LSS_CFG_RATE && rx_frame.data[23:16] > 8'h07)
        ? 8'h01 : 8'h00;
    wire lss_ack = (lss_sel_hit && lss_step_r == 2'd3) || lss_cfg;

    // tpdo images, in entry order
    logic [63:0] pdo_img [0:NUM_TPDO-1];
    logic [NUM_TPDO-1:0] pdo_go;
    genvar gp, ge;
    generate
        for (gp = 0; gp < NUM_TPDO; gp++) begin : g_pdo
            for (ge = 0; ge < MAP_DEPTH; ge++) begin : g_ent
                assign pdo_img[gp][ge*8 +: 8] = ge < map_cnt_r[gp]
                    ? app_bytes[map_src_r[gp][ge]*8 +: 8]
                    : 8'h00;
            end
            assign pdo_go[gp] = tpdo_pend_r[gp] && !tpdo_dis_r[gp];
        end
    endgenerate
    logic [2:0] go_sel;
    always_comb begin
        go_sel = 3'h0;
        for (int i = NUM_TPDO - 1; i >= 0; i--)
            if (pdo_go[i])
                go_sel = 3'(i);
    end
    wire oper = state_r == cosl_pkg::COSL_OPER;
    wire send_guard = is_guard && state_r != cosl_pkg::COSL_INIT;

    // transmit arbitration: replies first, then emergency, then pdo
    cosl_pkg::cosl_frame_type tx_nxt;
    logic tx_load;
    always_comb begin
        tx_nxt = tx_r;
        tx_load = 1'b0;
        if (can_push) begin
            if (is_sdo) begin
                tx_load = 1'b1;
                tx_nxt.id = cosl_pkg::SDO_TX_BASE | {4'h0, node_r};
                tx_nxt.data = {sdo_rsp_dat, sub, idx, sdo_rsp_cmd};
            end else if (send_guard) begin
                tx_load = 1'b1;
                tx_nxt.id = cosl_pkg::GUARD_BASE | {4'h0, node_r};
                tx_nxt.data = {56'h0, guard_tog_r, 7'(state_r == 
                    cosl_pkg::COSL_OPER ? 7'h05 : state_r ==
                    cosl_pkg::COSL_STOPPED ? 7'h04 : 7'h7f)};
            end else if (lss_ack) begin
                tx_load = 1'b1;
                tx_nxt.id = cosl_pkg::LSS_TX_ID;
                tx_nxt.data = {48'h0, lss_cfg ? lss_err : 8'h00,
                    lss_cfg ? b0 : cosl_pkg::LSS_SEL_ACK};
            end else if (oper && emcy_pend_r) begin
                tx_load = 1'b1;
                tx_nxt.id = cosl_pkg::EMCY_BASE | {4'h0, node_r};
                tx_nxt.data = emcy_data;
            end else if (oper && |pdo_go) begin
                tx_load = 1'b1;
                tx_nxt.id = cosl_pkg::TPDO_BASE + {4'h0, node_r}
                    + 11'(go_sel[1:0]) * cosl_pkg::TPDO_STEP;
                tx_nxt.data = pdo_img[go_sel];
            end
            tx_nxt.len = cosl_pkg::FRAME_LEN;
        end
    end
    wire pdo_sent = tx_load && oper && !is_sdo && !send_guard && !lss_ack
        && !emcy_pend_r && |pdo_go;
    wire emcy_sent = tx_load && oper && !is_sdo && !send_guard && !lss_ack
        && emcy_pend_r;
    wire sdo_commit = is_sdo && can_push && sdo_wr && wr_ok;

    // persistent settings and nmt state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r     <= cosl_pkg::COSL_INIT;
            node_r      <= cosl_pkg::NODE_ID_DEFAULT;
            pend_node_r <= cosl_pkg::NODE_ID_DEFAULT;
            rate_r      <= cosl_pkg::RATE_DEFAULT;
            guard_tog_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (factory_reset) begin
                pend_node_r <= cosl_pkg::NODE_ID_DEFAULT;
                rate_r      <= cosl_pkg::RATE_DEFAULT;
            end else if (sdo_commit && wr_id_ok)
                pend_node_r <= wdat[6:0];
            else if (lss_cfg && b0 == cosl_pkg::LSS_CFG_ID && lss_id_ok)
                pend_node_r <= rx_frame.data[14:8];
            if (sdo_commit && wr_rate_ok)
                rate_r <= wdat[2:0];
            else if (lss_cfg && b0 == cosl_pkg::LSS_CFG_RATE
                     && lss_err == 8'h00)
                rate_r <= rx_frame.data[18:16];
            if (is_nmt && b0 == cosl_pkg::NMT_RESET)
                node_r <= pend_node_r;
            if (send_guard && tx_load)
                guard_tog_r <= !guard_tog_r;
        end
    end

    // lss selection progress
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lss_sel_r  <= 1'b0;
            lss_step_r <= 2'd0;
        end else if (is_lss && b0 == cosl_pkg::LSS_SW_GLOBAL) begin
            lss_sel_r  <= rx_frame.data[8];
            lss_step_r <= 2'd0;
        end else if (lss_sel_hit) begin
            lss_step_r <= lss_step_r + 2'd1;
            lss_sel_r  <= lss_step_r == 2'd3;
        end else if (is_lss && b0 >= cosl_pkg::LSS_SEL_VENDOR
                     && b0 <= cosl_pkg::LSS_SEL_SERIAL)
            lss_step_r <= 2'd0;
    end

    // mapping and pdo control, cleared on reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tpdo_dis_r  <= '0;
            tpdo_pend_r <= '0;
            emcy_pend_r <= 1'b0;
            for (int p = 0; p < NUM_TPDO; p++) begin
                map_cnt_r[p] <= 4'h0;
                for (int e = 0; e < MAP_DEPTH; e++)
                    map_src_r[p][e] <= 8'h00;
            end
        end else begin
            tpdo_pend_r <= (tpdo_pend_r & ~(pdo_sent
                ? NUM_TPDO'(1) << go_sel : '0)) | tpdo_trigger;
            emcy_pend_r <= (emcy_pend_r && !emcy_sent) || (emcy_request
                && oper);
            if (sdo_commit && wr_comm_ok)
                tpdo_dis_r[pi] <= wdat[cosl_pkg::COMM_DIS_BIT];
            if (sdo_commit && wr_map_ok && sub == 8'h00)
                map_cnt_r[pi] <= wdat[3:0];
            else if (sdo_commit && wr_map_ok)
                map_src_r[pi][sub[2:0] - 3'h1] <= wdat[23:16];
        end
    end

    // rpdo capture, tx register, nonvolatile commit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_r     <= '0;
            tx_v_r   <= 1'b0;
            nv_write <= 1'b0;
            nv_index <= 16'h0;
            nv_data  <= 32'h0;
            for (int k = 0; k < 8; k++)
                rpdo_data[k] <= 8'h00;
        end else begin
            tx_r   <= tx_nxt;
            tx_v_r <= tx_load || (tx_v_r && !tx_ready);
            nv_write <= sdo_commit && !is_map;
            nv_index <= idx;
            nv_data  <= wdat;
            if (is_rpdo)
                for (int k = 0; k < 8; k++)
                    rpdo_data[k] <= rx_frame.data[k*8 +: 8];
        end
    end

    assign tx_frame  = tx_r;
    assign tx_valid  = tx_v_r;
    assign nmt_state = state_r;
    assign node_id   = node_r;
    assign bit_rate  = rate_r;
endmodule // cosl_slave
`default_nettype wire

//--- cosl_chk.sv
// Purpose: port assertions
// Assumes: one clock, async reset
// Notes:   bound from tb_top
`default_nettype none
module cosl_chk (
    // clock and reset
    input wire logic                     clock,
    input wire logic                     rst,
    // frames
    input wire cosl_pkg::cosl_frame_type rx_frame,
    input wire logic                     rx_valid,
    input wire cosl_pkg::cosl_frame_type tx_frame,
    input wire logic                     tx_valid,
    input wire logic                     tx_ready,
    // status
    input wire logic                     app_init_done,
    input wire logic                     nv_write,
    input wire logic [15:0]              nv_index,
    input wire cosl_pkg::cosl_state_type nmt_state,
    input wire logic [6:0]               node_id
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // tx path free, node-relative ids
    wire logic        tx_free = !tx_valid || tx_ready;
    wire logic [10:0] nd      = {4'h0, node_id};
    // request taken with tx path free
    sequence s_rx(logic [10:0] id);
        rx_valid && tx_free && rx_frame.id == id;
    endsequence
    sequence s_nmt(logic [7:0] cmd);
        s_rx(11'h000) ##0 rx_frame.data[15:0] == {8'h00, cmd};
    endsequence
    property p_boot;
        nmt_state == 3'h0 && app_init_done && !rx_valid
            |-> ##[1:4] nmt_state == 3'h1;
    endproperty
    a_boot: assert property (p_boot) else $error("no preop after init");
    property p_quiet;
        tx_valid && nmt_state != 3'h3 && $past(nmt_state) != 3'h3
            |-> !(tx_frame.id inside {[11'h081:11'h4ff]});
    endproperty
    a_quiet: assert property (p_quiet) else $error("pdo or emcy off oper");
    property p_len;
        tx_valid |-> tx_frame.len == 4'h8;
    endproperty
    a_len: assert property (p_len) else $error("frame not 8 bytes");
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame);
    endproperty
    a_hold: assert property (p_hold) else $error("tx frame not held");
    property p_sdo;
        s_rx(11'h600 + nd) ##0 nmt_state[0]
            |=> tx_valid && tx_frame.id == 11'h580 + nd;
    endproperty
    a_sdo: assert property (p_sdo) else $error("sdo request unanswered");
    property p_guard;
        s_rx(11'h700 + nd) ##0 nmt_state == 3'h2 |=> tx_valid
            && tx_frame.id == 11'h700 + nd
            && tx_frame.data[6:0] == 7'h04;
    endproperty
    a_guard: assert property (p_guard) else $error("guard not answered");
    property p_lss;
        s_rx(11'h7e5) ##0 rx_frame.data[7:0] == 8'h13 |=> tx_valid
            && tx_frame.id == 11'h7e4 && tx_frame.data[7:0] == 8'h13;
    endproperty
    a_lss: assert property (p_lss) else $error("lss reply wrong");
    property p_nv;
        $rose(tx_valid) && tx_frame.id == 11'h580 + nd
            && tx_frame.data[7:0] == 8'h60 && tx_frame.data[23:12] != 12'h1a0
            |-> nv_write && nv_index == tx_frame.data[23:8];
    endproperty
    a_nv: assert property (p_nv) else $error("write not committed");
    property p_reset_cmd;
        s_nmt(8'h81) |=> nmt_state == 3'h0;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("no reset");
    property p_start;
        s_nmt(8'h01) ##0 nmt_state == 3'h1 |=> nmt_state == 3'h3;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_node;
        node_id != 7'h00;
    endproperty
    a_node: assert property (p_node) else $error("node id zero");
endmodule // cosl_chk
`default_nettype wire

//--- cosl_master_model.sv
// Purpose: network master model
// Assumes: replies taken after stall cycles
// Notes:   released request lines show the inverse
`default_nettype none
module cosl_master_model (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst,
    // toward the slave
    output var  cosl_pkg::cosl_frame_type rx_frame,
    output logic                          rx_valid,
    // from the slave
    input  wire cosl_pkg::cosl_frame_type tx_frame,
    input  wire logic                     tx_valid,
    output logic                          tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    int stall = 0;
    // idle lines at time zero
    initial begin
        rx_frame = '0;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    // one frame, one cycle
    task automatic send(input logic [10:0] id, input logic [63:0] d);
        @(posedge clock);
        rx_frame <= {id, 4'h8, d};
        rx_valid <= 1'b1;
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_frame <= ~rx_frame;
    endtask
    // take one reply
    task automatic get(output cosl_pkg::cosl_frame_type f, output bit got);
        got = 1'b0;
        f   = '0;
        for (int i = 0; i < 24 && !got; i++) begin
            @(posedge clock);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                f = tx_frame;
                got = 1'b1;
                tx_ready <= 1'b0;
            end else if (tx_valid === 1'b1 && i >= stall)
                tx_ready <= 1'b1;
        end
    endtask
endmodule // cosl_master_model
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench
// Assumes: master model takes each reply, after stall cycles when stalled
// Notes:   node 6 then 5
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     clock, rst, rx_valid, tx_valid, tx_ready;
    logic                     app_init_done, emcy_request, nv_write;
    cosl_pkg::cosl_frame_type rx_frame, tx_frame, f;
    cosl_pkg::cosl_state_type nmt_state;
    logic [5:0]               tpdo_trigger;
    logic [255:0]             app_bytes;
    logic [15:0]              nv_index, nv_last;
    logic [31:0]              nv_data;
    logic [6:0]               node_id;
    logic [2:0]               bit_rate;
    logic [7:0]               rpdo_data [0:7];
    bit                       g;
    int                       error_cnt = 0, n_checks = 0, nv_cnt = 0;
    localparam logic [31:0]   VEND = 32'h0000_00a5; // arbitrary
    cosl_slave #(.VENDOR_CODE(VEND)) i_cosl_slave (.clock(clock),
        .rst(rst), .rx_frame(rx_frame), .rx_valid(rx_valid),
        .tx_frame(tx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .app_init_done(app_init_done), .tpdo_trigger(tpdo_trigger),
        .emcy_request(emcy_request), .emcy_data(64'h0),
        .app_bytes(app_bytes), .factory_reset(1'b0), .nv_write(nv_write),
        .nv_index(nv_index), .nv_data(nv_data), .nmt_state(nmt_state),
        .node_id(node_id), .bit_rate(bit_rate), .rpdo_data(rpdo_data));
    cosl_master_model i_cosl_master_model (.clock(clock), .rst(rst),
        .rx_frame(rx_frame), .rx_valid(rx_valid), .tx_frame(tx_frame),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    always #50 clock = ~clock;
    // count committed writes
    always @(posedge clock) begin
        if (nv_write === 1'b1) begin
            nv_cnt++;
            nv_last = nv_index;
        end
    end
    task automatic gt;
        i_cosl_master_model.get(f, g);
    endtask
    task automatic rq(input logic [10:0] id, input logic [63:0] d);
        i_cosl_master_model.send(id, d);
        gt();
    endtask
    task automatic trig(input logic [5:0] t);
        @(posedge clock);
        tpdo_trigger <= t;
        emcy_request <= 1'b1;
        @(posedge clock);
        tpdo_trigger <= 6'h00;
        emcy_request <= 1'b0;
    endtask
    task automatic t_boot;
        `CHK("init", 3'h0, nmt_state)
        `CHK("node", 7'h06, node_id)
        `CHK("rate", 3'h3, bit_rate)
        app_init_done <= 1'b1;
        repeat (5) @(posedge clock);
        `CHK("preop", 3'h1, nmt_state)
    endtask
    task automatic t_sdo;
        rq(11'h606, {32'h0, 8'h01, 16'h1018, 8'h40});
        `CHK("rd_id", 11'h586, f.id)
        `CHK("rd_cmd", 8'h43, f.data[7:0])
        `CHK("vendor", VEND, f.data[63:32])
        rq(11'h606, {32'h0, 8'h00, 16'h2100, 8'h20});
        `CHK("abort", 8'h80, f.data[7:0])
        `CHK("code", 32'h0609_0030, f.data[63:32])
        rq(11'h606, {32'h5, 8'h00, 16'h2100, 8'h20});
        `CHK("wr", 8'h60, f.data[7:0])
        `CHK("nv", 1, nv_cnt)
        `CHK("nv_idx", 16'h2100, nv_last)
        `CHK("old_node", 7'h06, node_id)
    endtask
    task automatic t_restart;
        rq(11'h000, 64'h81);
        repeat (6) @(posedge clock);
        `CHK("new_node", 7'h05, node_id)
        `CHK("preop2", 3'h1, nmt_state)
        // remap after restart, pdo 1 off
        rq(11'h605, {32'h0002_0008, 8'h01, 16'h1a00, 8'h20});
        rq(11'h605, {32'h1, 8'h00, 16'h1a00, 8'h20});
        rq(11'h605, {32'h8000_0000, 8'h01, 16'h1801, 8'h20});
        `CHK("dis", 8'h60, f.data[7:0])
        trig(6'h03);
        gt();
        `CHK("quiet", 1'b0, g)
    endtask
    task automatic t_oper;
        i_cosl_master_model.send(11'h000, 64'h01);
        trig(6'h03);
        gt();
        `CHK("oper", 3'h3, nmt_state)
        `CHK("tpdo_id", 11'h185, f.id)
        `CHK("tpdo_map", 8'h5a, f.data[7:0])
        gt();
        `CHK("emcy", 11'h085, f.id)
        gt();
        `CHK("off", 11'h185, f.id)
        i_cosl_master_model.send(11'h000, 64'h02);
        i_cosl_master_model.stall = 3;
        trig(6'h01);
        `CHK("stopped", 3'h2, nmt_state)
        rq(11'h705, 64'h0);
        `CHK("gid", 11'h705, f.id)
        `CHK("gst", 7'h04, f.data[6:0])
        i_cosl_master_model.stall = 0;
        rq(11'h7e5, 64'h0104);
        rq(11'h7e5, 64'h0005_0013);
        `CHK("lss_id", 11'h7e4, f.id)
        `CHK("lss_cs", 16'h0013, f.data[15:0])
        `CHK("lss_pad", 48'h0, f.data[63:16])
        `CHK("rate5", 3'h5, bit_rate)
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        results();
    end
    // main sequence
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        app_init_done = 1'b0;
        emcy_request = 1'b0;
        tpdo_trigger = 6'h00;
        app_bytes = {{29{8'hc3}}, 8'h5a, 16'hc3c3};
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_boot();
        t_sdo();
        t_restart();
        t_oper();
        results();
    end
endmodule // tb_top
bind cosl_slave cosl_chk i_cosl_chk (.clock(clock), .rst(rst),
    .rx_frame(rx_frame), .rx_valid(rx_valid), .tx_frame(tx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .app_init_done(app_init_done),
    .nv_write(nv_write), .nv_index(nv_index), .nmt_state(nmt_state),
    .node_id(node_id));
`undef CHK
`default_nettype wire
